// ---- sim/rtc_regs_properties.sv ----
// checker for the receiver tuning configuration bank
// assumes bind onto rtc_regs, single clock, sync reset
`timescale 1ns/1ps
module rtc_regs_props (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic preamble_short_i,
  input wire logic [1:0] rx_phase_i,
  input wire logic filter_run_i,
  input wire logic [7:0] test_bus_addr_o,
  input wire logic coef_abs_o,
  input wire logic [6:0] coef_level_o,
  input wire logic [6:0] scrambler_seed_o,
  input wire logic energy_flag_o,
  input wire logic gain_double_o,
  input wire logic [5:0] lead_coef_o,
  input wire logic [5:0] lag_coef_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // ------------------------------------------------------------
  // write sequences and properties
  // ------------------------------------------------------------
  sequence s_wr(logic [7:0] a);
    wr_i && addr_i == a;
  endsequence
  sequence s_long_then_sel;
    s_wr(8'h48) ##1 !preamble_short_i;
  endsequence
  property p_tb;
    s_wr(8'h44) |=> test_bus_addr_o == $past(wdata_i);
  endproperty
  property p_coef;
    s_wr(8'h46) |=> {coef_abs_o, coef_level_o} == $past(wdata_i);
  endproperty
  property p_seed;
    s_long_then_sel |-> scrambler_seed_o == $past(wdata_i[6:0]);
  endproperty
  property p_rd_idle;
    !rd_i |=> rdata_o == 8'h00;
  endproperty
  property p_readback;
    rd_i && addr_i == 8'h44 |=> rdata_o == $past(test_bus_addr_o);
  endproperty
  property p_idle_coef;
    rx_phase_i == 2'd3 |-> lead_coef_o == 6'h00 && lag_coef_o == 6'h00;
  endproperty
  property p_gain_off;
    !filter_run_i |=> !gain_double_o;
  endproperty
  property p_rx;
    rd_i && addr_i == 8'h94 |=> rdata_o[4] == $past(energy_flag_o);
  endproperty
  property p_mask0;
    s_wr(8'h92) ##0 wdata_i == 8'h00 |-> ##[1:2] !irq_o;
  endproperty
  a_tb: assert property (p_tb) else $error("test bus mismatch");
  a_coef: assert property (p_coef) else $error("coef mismatch");
  a_seed: assert property (p_seed) else $error("seed mismatch");
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not 0");
  a_readback: assert property (p_readback) else $error("readback");
  a_idle_coef: assert property (p_idle_coef) else $error("no coef");
  a_gain_off: assert property (p_gain_off) else $error("gain on");
  a_rx: assert property (p_rx) else $error("rx status bit");
  a_mask0: assert property (p_mask0) else $error("irq masked");
endmodule

bind rtc_regs rtc_regs_props u_props (.clock_i(clock_i), .srst_i(srst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .preamble_short_i(preamble_short_i),
  .rx_phase_i(rx_phase_i), .filter_run_i(filter_run_i),
  .test_bus_addr_o(test_bus_addr_o), .coef_abs_o(coef_abs_o),
  .coef_level_o(coef_level_o), .scrambler_seed_o(scrambler_seed_o),
  .energy_flag_o(energy_flag_o), .gain_double_o(gain_double_o),
  .lead_coef_o(lead_coef_o), .lag_coef_o(lag_coef_o), .irq_o(irq_o));

// ---- sim/rtc_regs_test.sv ----
// self-checking bench for the receiver tuning configuration bank
// assumes rtc_regs with the plain register port, 50 ns clock
`timescale 1ns/1ps
module rtc_regs_test;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, noise_floor_i = 8'h00;
  logic wr_i = 1'b0, rd_i = 1'b0, preamble_short_i = 1'b0;
  logic filter_run_i = 1'b0, peak_valid_i = 1'b0;
  logic [1:0] rx_phase_i = 2'd3;
  logic [7:0] energy_i = 8'h00, rssi_i = 8'hff, peak_i = 8'h00, got;
  logic [7:0] rdata_o, test_bus_addr_o, rv [13];
  logic [6:0] coef_level_o, scrambler_seed_o;
  logic [5:0] lead_coef_o, lag_coef_o;
  logic coef_abs_o, energy_flag_o, antenna_search_o, gain_double_o, irq_o;
  int errors = 0, checks = 0, seed = 96794;
  rtc_regs DUT (.clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .preamble_short_i(preamble_short_i), .rx_phase_i(rx_phase_i),
    .noise_floor_i(noise_floor_i), .energy_i(energy_i), .rssi_i(rssi_i),
    .filter_run_i(filter_run_i), .peak_valid_i(peak_valid_i),
    .peak_i(peak_i), .test_bus_addr_o(test_bus_addr_o),
    .coef_abs_o(coef_abs_o), .coef_level_o(coef_level_o),
    .scrambler_seed_o(scrambler_seed_o), .energy_flag_o(energy_flag_o),
    .antenna_search_o(antenna_search_o), .gain_double_o(gain_double_o),
    .lead_coef_o(lead_coef_o), .lag_coef_o(lag_coef_o), .irq_o(irq_o));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [8:0] lvl(input logic [7:0] v, f);
    lvl = v[7] ? {2'b00, v[6:0]} : {2'b00, v[6:0]} + {1'b0, f};
  endfunction
  function automatic logic [7:0] cf(input int k, q);
    cf = 8'h00;
    if (q != 3)
      cf = {2'b00, rv[k + 2 * q][5:0]};
  endfunction
  task automatic chk(input string n, input logic [7:0] e, g);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= w;
    rd_i <= !w;
    @(posedge clock_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    #1 got = rdata_o;
  endtask
  task automatic env(input logic [7:0] v, f, e, a, r);
    bus(1'b1, 8'h4c, v);
    bus(1'b1, 8'h50, a);
    @(posedge clock_i);
    noise_floor_i <= f;
    energy_i <= e;
    rssi_i <= r;
    repeat (3) @(posedge clock_i);
    #1 chk("energy", 8'({1'b0, e} > lvl(v, f)), energy_flag_o);
    chk("antenna", 8'({1'b0, r} < lvl(a, f)), antenna_search_o);
    bus(1'b0, 8'h94, 8'h00);
    chk("rx_status", 8'({1'b0, e} > lvl(v, f)), 8'(got[4]));
  endtask
  task automatic gain(input logic [7:0] thr, pk);
    logic [7:0] eg;
    eg = 8'(thr != 0 && 11'(pk) * 8 < 11'(thr));
    bus(1'b1, 8'h4e, thr);
    @(posedge clock_i);
    filter_run_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    peak_i <= pk;
    peak_valid_i <= 1'b1;
    repeat (8) @(posedge clock_i);
    peak_valid_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    #1 chk("gain", eg, 8'(gain_double_o));
    bus(1'b0, 8'h90, 8'h00);
    chk("gain_evt", eg, 8'(got[2]));
    bus(1'b1, 8'h90, 8'h04);
    bus(1'b0, 8'h90, 8'h00);
    chk("gain_clr", 8'h00, 8'(got[2]));
    @(posedge clock_i);
    filter_run_i <= 1'b0;
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ------------------------------------------------------------
  // clock, watchdog, sequence
  // ------------------------------------------------------------
  initial
  begin
    forever #25 clock_i = ~clock_i;
  end
  initial
  begin
    #500000;
    errors++;
    give_verdict;
  end
  initial
  begin
    repeat (4) @(posedge clock_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      bus(1'b0, 8'h44 + 8'(2 * i), 8'h00);
      chk("reset", 8'h00, got);
      rv[i % 13] = $random(seed);
    end
    rv[1] = 8'h80;
    rv[7] = 8'he0;
    for (int i = 0; i < 13; i++)
      bus(1'b1, 8'h44 + 8'(2 * i), rv[i]);
    bus(1'b1, 8'h60, 8'hff);
    bus(1'b0, 8'h60, 8'h00);
    chk("unmapped", 8'h00, got);
    for (int i = 0; i < 13; i++)
    begin
      bus(1'b0, 8'h44 + 8'(2 * i), 8'h00);
      chk("readback", rv[i], got);
    end
    chk("test_bus", rv[0], test_bus_addr_o);
    chk("coef", rv[1], {coef_abs_o, coef_level_o});
    bus(1'b1, 8'h46, 8'h7f);
    #1 chk("coef_dflt", 8'h7f, {coef_abs_o, coef_level_o});
    for (int p = 0; p < 4; p++)
    begin
      @(posedge clock_i);
      preamble_short_i <= p[0];
      rx_phase_i <= 2'(p);
      @(posedge clock_i);
      #1 chk("seed", 8'(rv[2 + p % 2][6:0]), 8'(scrambler_seed_o));
      chk("lead", cf(7, p), 8'(lead_coef_o));
      chk("lag", cf(8, p), 8'(lag_coef_o));
    end
    env(8'h85, 8'h00, 8'h05, 8'h03, 8'h10);
    env(8'h05, 8'h10, 8'h16, 8'h7f, 8'h70);
    repeat (8) env($random(seed), $random(seed), $random(seed),
      $random(seed), $random(seed));
    gain(8'h00, 8'h01);
    gain(8'h10, 8'h02);
    gain(8'h11, 8'h02);
    gain($random(seed), $random(seed));
    env(8'h80, 8'h00, 8'h00, 8'h80, 8'hff);
    bus(1'b1, 8'h90, 8'hff);
    bus(1'b1, 8'h92, 8'h00);
    bus(1'b0, 8'h90, 8'h00);
    chk("status_clr", 8'h00, got);
    @(posedge clock_i);
    energy_i <= 8'h10;
    repeat (3) @(posedge clock_i);
    bus(1'b0, 8'h90, 8'h00);
    chk("status_set", 8'h01, got);
    chk("irq_masked", 8'h00, 8'(irq_o));
    bus(1'b1, 8'h92, 8'h01);
    repeat (2) @(posedge clock_i);
    #1 chk("irq_on", 8'h01, 8'(irq_o));
    bus(1'b1, 8'h90, 8'h01);
    repeat (2) @(posedge clock_i);
    #1 chk("irq_off", 8'h00, 8'(irq_o));
    give_verdict;
  end
endmodule

// ---- verilog/rtc_pkg.sv ----
// receiver tuning configuration bank: offsets, fields, reset values
// assumes byte-wide registers at even byte offsets on a plain port
package rtc_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_TEST_BUS_SELECT = 8'h44;
  localparam logic [7:0] OFS_COEF_CONTROL_THRESHOLD = 8'h46;
  localparam logic [7:0] OFS_SCRAMBLER_SEED_LONG = 8'h48;
  localparam logic [7:0] OFS_SCRAMBLER_SEED_SHORT = 8'h4a;
  localparam logic [7:0] OFS_ENERGY_DETECT_THRESHOLD = 8'h4c;
  localparam logic [7:0] OFS_FILTER_GAIN_THRESHOLD = 8'h4e;
  localparam logic [7:0] OFS_ANTENNA_SEARCH_THRESHOLD = 8'h50;
  localparam logic [7:0] OFS_PREAMBLE_LEAD_COEF = 8'h52;
  localparam logic [7:0] OFS_PREAMBLE_LAG_COEF = 8'h54;
  localparam logic [7:0] OFS_HEADER_LEAD_COEF = 8'h56;
  localparam logic [7:0] OFS_HEADER_LAG_COEF = 8'h58;
  localparam logic [7:0] OFS_DATA_LEAD_COEF = 8'h5a;
  localparam logic [7:0] OFS_DATA_LAG_COEF = 8'h5c;
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h90;
  localparam logic [7:0] OFS_EVENT_MASK = 8'h92;
  localparam logic [7:0] OFS_RX_STATUS = 8'h94;

  // ------------------------------------------------------------
  // fields and reset values
  // ------------------------------------------------------------
  localparam int MODE_BIT = 7;
  localparam int LEVEL_MSB = 6;
  localparam int SEED_MSB = 6;
  localparam int COEF_MSB = 5;
  localparam int ENERGY_FLAG_BIT = 4;
  localparam int EVT_ENERGY = 0;
  localparam int EVT_ANTENNA = 1;
  localparam int EVT_GAIN = 2;
  localparam int EVT_W = 3;
  localparam int PEAK_COUNT = 8;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {PH_PREAMBLE, PH_HEADER, PH_DATA, PH_IDLE}
    rtc_phase_t;
  typedef enum {GS_IDLE, GS_ACCUM, GS_DONE} rtc_gain_state_t;

endpackage

// ---- verilog/rtc_regs.sv ----
// receiver tuning configuration bank with threshold compare logic
// assumes a synchronous register port and datapath inputs on clock_i
`timescale 1ns/1ps

// Functional notes
// R1 - 8-bit test bus address register selects routed internal test signals.
// R2 - coefficient threshold bit 7: 0 noise-floor relative, 1 absolute.
// R3 - software writes 80h or 7fh for calculated or default weights.
// R4 - two 7-bit seeds; preamble-type bit chooses which loads scrambler.
// R5 - energy mode bit 7: 0 floor plus threshold, 1 absolute level.
// R6 - energy threshold unsigned 0-127, compared to decide channel busy.
// R7 - sum 8 correlation peaks, compare with gain threshold, double gain.
// R8 - gain threshold zero disables the gain-doubling step entirely.
// R9 - signal below antenna threshold starts search; bit 7 selects reference.
// R10 - antenna threshold is 7-bit unsigned in low bits, 0-127.
// R11 - preamble lead/lag coefficients 6-bit, 100000 means 4.
// R12 - header lead/lag coefficients held in own registers, same encoding.
// R13 - data lead/lag coefficients held in own registers, same encoding.
// R14 - unused upper bits read back written value, no internal effect; event status and mask bits 7:3 read back as zero.
// R15 - readable receive-status bit shows energy above threshold.
// R16 - all registers 8-bit readable, reset to zero.
module rtc_regs (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic preamble_short_i,
  input wire logic [1:0] rx_phase_i,
  input wire logic [7:0] noise_floor_i,
  input wire logic [7:0] energy_i,
  input wire logic [7:0] rssi_i,
  input wire logic filter_run_i,
  input wire logic peak_valid_i,
  input wire logic [7:0] peak_i,
  output logic [7:0] test_bus_addr_o,
  output logic coef_abs_o,
  output logic [6:0] coef_level_o,
  output logic [6:0] scrambler_seed_o,
  output logic energy_flag_o,
  output logic antenna_search_o,
  output logic gain_double_o,
  output logic [5:0] lead_coef_o,
  output logic [5:0] lag_coef_o,
  output logic irq_o
);

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [7:0] test_bus_select_r;
  logic [7:0] coef_control_threshold_r;
  logic [7:0] long_seed_register_r;
  logic [7:0] short_seed_register_r;
  logic [7:0] energy_detect_threshold_r;
  logic [7:0] filter_gain_threshold_r;
  logic [7:0] antenna_search_threshold_r;
  logic [7:0] preamble_lead_coef_r;
  logic [7:0] preamble_lag_coef_r;
  logic [7:0] header_lead_coef_r;
  logic [7:0] header_lag_coef_r;
  logic [7:0] data_lead_coef_r;
  logic [7:0] data_lag_coef_r;
  logic [rtc_pkg::EVT_W-1:0] status_r;
  logic [rtc_pkg::EVT_W-1:0] mask_r;
  logic [rtc_pkg::EVT_W-1:0] events;
  logic [7:0] rdata_nxt;
  logic energy_thresh_level_nxt;
  logic antenna_low_nxt;
  logic energy_flag_r;
  logic antenna_search_r;
  logic gain_double_r;
  logic energy_rise;
  logic antenna_rise;
  logic [10:0] peak_sum_r;
  logic [3:0] peak_cnt_r;
  rtc_pkg::rtc_gain_state_t gain_state_r;
  logic gain_headroom;
  logic gain_eval;

  // level check: relative adds noise floor, absolute uses value alone
  function automatic logic [8:0] ref_level(input logic abs_mode,
                                           input logic [6:0] value,
                                           input logic [7:0] floor_v);
    logic [8:0] sum_v;
    sum_v = {2'h0, value};
    if (!abs_mode)
    begin
      sum_v = sum_v + {1'h0, floor_v};
    end
    return sum_v;
  endfunction

  function automatic logic hit(input logic [7:0] a_v);
    return (addr_i == a_v);
  endfunction

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  // test bus and coefficient control
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      test_bus_select_r <= rtc_pkg::REG_RESET; // see R16
      coef_control_threshold_r <= rtc_pkg::REG_RESET;
    end
    else if (wr_i)
    begin
      // full 8 bits stored, unused bits kept for readback, see R14
      if (hit(rtc_pkg::OFS_TEST_BUS_SELECT))
        test_bus_select_r <= wdata_i; // see R1
      if (hit(rtc_pkg::OFS_COEF_CONTROL_THRESHOLD))
        coef_control_threshold_r <= wdata_i; // see R3
    end
  end

  // scrambler seeds
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      long_seed_register_r <= rtc_pkg::REG_RESET;
      short_seed_register_r <= rtc_pkg::REG_RESET;
    end
    else if (wr_i)
    begin
      if (hit(rtc_pkg::OFS_SCRAMBLER_SEED_LONG))
        long_seed_register_r <= wdata_i; // see R4
      if (hit(rtc_pkg::OFS_SCRAMBLER_SEED_SHORT))
        short_seed_register_r <= wdata_i; // see R4
    end
  end

  // detect, gain and search thresholds
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      energy_detect_threshold_r <= rtc_pkg::REG_RESET;
      filter_gain_threshold_r <= rtc_pkg::REG_RESET;
      antenna_search_threshold_r <= rtc_pkg::REG_RESET;
    end
    else if (wr_i)
    begin
      if (hit(rtc_pkg::OFS_ENERGY_DETECT_THRESHOLD))
        energy_detect_threshold_r <= wdata_i;
      if (hit(rtc_pkg::OFS_FILTER_GAIN_THRESHOLD))
        filter_gain_threshold_r <= wdata_i;
      if (hit(rtc_pkg::OFS_ANTENNA_SEARCH_THRESHOLD))
        antenna_search_threshold_r <= wdata_i;
    end
  end

  // loop coefficients per phase
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      preamble_lead_coef_r <= rtc_pkg::REG_RESET;
      preamble_lag_coef_r <= rtc_pkg::REG_RESET;
      header_lead_coef_r <= rtc_pkg::REG_RESET;
      header_lag_coef_r <= rtc_pkg::REG_RESET;
      data_lead_coef_r <= rtc_pkg::REG_RESET;
      data_lag_coef_r <= rtc_pkg::REG_RESET;
    end
    else if (wr_i)
    begin
      if (hit(rtc_pkg::OFS_PREAMBLE_LEAD_COEF))
        preamble_lead_coef_r <= wdata_i; // see R11
      if (hit(rtc_pkg::OFS_PREAMBLE_LAG_COEF))
        preamble_lag_coef_r <= wdata_i; // see R11
      if (hit(rtc_pkg::OFS_HEADER_LEAD_COEF))
        header_lead_coef_r <= wdata_i; // see R12
      if (hit(rtc_pkg::OFS_HEADER_LAG_COEF))
        header_lag_coef_r <= wdata_i; // see R12
      if (hit(rtc_pkg::OFS_DATA_LEAD_COEF))
        data_lead_coef_r <= wdata_i; // see R13
      if (hit(rtc_pkg::OFS_DATA_LAG_COEF))
        data_lag_coef_r <= wdata_i; // see R13
    end
  end

  // interrupt mask
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      mask_r <= '0;
    else if (wr_i && hit(rtc_pkg::OFS_EVENT_MASK))
      mask_r <= wdata_i[rtc_pkg::EVT_W-1:0];
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always_comb
  begin
    rdata_nxt = rtc_pkg::UNMAPPED_READ;
    case (addr_i)
      rtc_pkg::OFS_TEST_BUS_SELECT: rdata_nxt = test_bus_select_r;
      rtc_pkg::OFS_COEF_CONTROL_THRESHOLD:
        rdata_nxt = coef_control_threshold_r;
      rtc_pkg::OFS_SCRAMBLER_SEED_LONG: rdata_nxt = long_seed_register_r;
      rtc_pkg::OFS_SCRAMBLER_SEED_SHORT: rdata_nxt = short_seed_register_r;
      rtc_pkg::OFS_ENERGY_DETECT_THRESHOLD:
        rdata_nxt = energy_detect_threshold_r;
      rtc_pkg::OFS_FILTER_GAIN_THRESHOLD:
        rdata_nxt = filter_gain_threshold_r;
      rtc_pkg::OFS_ANTENNA_SEARCH_THRESHOLD:
        rdata_nxt = antenna_search_threshold_r;
      rtc_pkg::OFS_PREAMBLE_LEAD_COEF: rdata_nxt = preamble_lead_coef_r;
      rtc_pkg::OFS_PREAMBLE_LAG_COEF: rdata_nxt = preamble_lag_coef_r;
      rtc_pkg::OFS_HEADER_LEAD_COEF: rdata_nxt = header_lead_coef_r;
      rtc_pkg::OFS_HEADER_LAG_COEF: rdata_nxt = header_lag_coef_r;
      rtc_pkg::OFS_DATA_LEAD_COEF: rdata_nxt = data_lead_coef_r;
      rtc_pkg::OFS_DATA_LAG_COEF: rdata_nxt = data_lag_coef_r;
      rtc_pkg::OFS_EVENT_STATUS: rdata_nxt = {5'h00, status_r};
      rtc_pkg::OFS_EVENT_MASK: rdata_nxt = {5'h00, mask_r};
      rtc_pkg::OFS_RX_STATUS:
      begin
        rdata_nxt = 8'h00;
        rdata_nxt[rtc_pkg::ENERGY_FLAG_BIT] = energy_flag_r; // see R15
      end
      default: rdata_nxt = rtc_pkg::UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      rdata_o <= 8'h00;
    else if (rd_i)
      rdata_o <= rdata_nxt;
    else
      rdata_o <= 8'h00;
  end

  // ------------------------------------------------------------
  // threshold compares
  // ------------------------------------------------------------
  always_comb
  begin
    // see R5 see R6
    energy_thresh_level_nxt = ({1'h0, energy_i} > ref_level(
      energy_detect_threshold_r[rtc_pkg::MODE_BIT],
      energy_detect_threshold_r[rtc_pkg::LEVEL_MSB:0], noise_floor_i));
    // see R9 see R10
    antenna_low_nxt = ({1'h0, rssi_i} < ref_level(
      antenna_search_threshold_r[rtc_pkg::MODE_BIT],
      antenna_search_threshold_r[rtc_pkg::LEVEL_MSB:0], noise_floor_i));
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      energy_flag_r <= 1'h0;
      antenna_search_r <= 1'h0;
    end
    else
    begin
      energy_flag_r <= energy_thresh_level_nxt; // see R15
      antenna_search_r <= antenna_low_nxt; // see R9
    end
  end

  assign energy_rise = energy_thresh_level_nxt && !energy_flag_r;
  assign antenna_rise = antenna_low_nxt && !antenna_search_r;

  // ------------------------------------------------------------
  // matched filter gain scaling
  // ------------------------------------------------------------
  // headroom when sum under threshold; zero disables, see R8
  assign gain_headroom = (filter_gain_threshold_r != 8'h00) &&
    (peak_sum_r < {3'h0, filter_gain_threshold_r}); // see R7
  // single cycle in which the eight-peak sum is judged
  assign gain_eval = filter_run_i && (gain_state_r == rtc_pkg::GS_ACCUM) &&
    (peak_cnt_r == 4'(rtc_pkg::PEAK_COUNT));

  always_ff @(posedge clock_i)
  begin
    if (srst_i || !filter_run_i)
    begin
      gain_state_r <= rtc_pkg::GS_IDLE;
      peak_sum_r <= 11'h000;
      peak_cnt_r <= 4'h0;
      gain_double_r <= 1'h0;
    end
    else
    begin
      case (gain_state_r)
        rtc_pkg::GS_IDLE:
        begin
          peak_sum_r <= 11'h000;
          peak_cnt_r <= 4'h0;
          gain_state_r <= rtc_pkg::GS_ACCUM;
        end
        rtc_pkg::GS_ACCUM:
        begin
          // peaks beyond the eighth are ignored
          if (peak_valid_i && (peak_cnt_r != 4'(rtc_pkg::PEAK_COUNT)))
          begin
            peak_sum_r <= peak_sum_r + {3'h0, peak_i}; // see R7
            peak_cnt_r <= peak_cnt_r + 4'h1;
          end
          if (gain_eval)
          begin
            gain_double_r <= gain_headroom; // see R7
            gain_state_r <= rtc_pkg::GS_DONE;
          end
        end
        rtc_pkg::GS_DONE: gain_state_r <= rtc_pkg::GS_DONE;
        default: gain_state_r <= rtc_pkg::GS_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // event status and interrupt
  // ------------------------------------------------------------
  always_comb
  begin
    events = '0;
    events[rtc_pkg::EVT_ENERGY] = energy_rise;
    events[rtc_pkg::EVT_ANTENNA] = antenna_rise;
    // one-cycle pulse so a clear can stick while the filter runs
    events[rtc_pkg::EVT_GAIN] = gain_eval && gain_headroom; // see R7
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      status_r <= '0;
    else if (wr_i && hit(rtc_pkg::OFS_EVENT_STATUS))
      status_r <= (status_r & ~wdata_i[rtc_pkg::EVT_W-1:0]) | events;
    else
      status_r <= status_r | events;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always_comb
  begin
    case (rtc_pkg::rtc_phase_t'(rx_phase_i))
      rtc_pkg::PH_PREAMBLE:
      begin
        lead_coef_o = preamble_lead_coef_r[rtc_pkg::COEF_MSB:0]; // see R11
        lag_coef_o = preamble_lag_coef_r[rtc_pkg::COEF_MSB:0];
      end
      rtc_pkg::PH_HEADER:
      begin
        lead_coef_o = header_lead_coef_r[rtc_pkg::COEF_MSB:0]; // see R12
        lag_coef_o = header_lag_coef_r[rtc_pkg::COEF_MSB:0];
      end
      rtc_pkg::PH_DATA:
      begin
        lead_coef_o = data_lead_coef_r[rtc_pkg::COEF_MSB:0]; // see R13
        lag_coef_o = data_lag_coef_r[rtc_pkg::COEF_MSB:0];
      end
      default:
      begin
        lead_coef_o = 6'h00;
        lag_coef_o = 6'h00;
      end
    endcase
  end

  assign test_bus_addr_o = test_bus_select_r; // see R1
  assign coef_abs_o = coef_control_threshold_r[rtc_pkg::MODE_BIT]; // see R2
  assign coef_level_o = coef_control_threshold_r[rtc_pkg::LEVEL_MSB:0];
  assign scrambler_seed_o = preamble_short_i ?
    short_seed_register_r[rtc_pkg::SEED_MSB:0] :
    long_seed_register_r[rtc_pkg::SEED_MSB:0]; // see R4
  assign energy_flag_o = energy_flag_r;
  assign antenna_search_o = antenna_search_r;
  assign gain_double_o = gain_double_r;
  assign irq_o = |(status_r & mask_r);

endmodule
